// ===== inc/fault_diag_pkg.sv
package fault_diag_pkg;
   localparam int NUM_CHANNELS = 12;
   // Mode bit positions within the two-bit mode word
   localparam int MODE_AUTO_BIT = 0;
   localparam int MODE_DETECT_BIT = 1;
   localparam logic [1:0] MODE_RESET = 2'h0;
   localparam logic [1:0] MODE_BOTH = 2'h3;

   typedef enum logic [1:0] {
      MODE_NONE = 2'b00,
      MODE_AUTO = 2'b01,
      MODE_DETECT = 2'b10,
      MODE_INVALID = 2'b11
   } diag_mode_type;
endpackage : fault_diag_pkg

// ===== inc/mode_bus_if.sv
`timescale 1ns/1ps
interface mode_bus_if;
   import fault_diag_pkg::*;
   logic [1:0] raw_mode;
   logic [1:0] eff_mode;
   modport src (output raw_mode, input eff_mode);
   modport sel (input raw_mode, output eff_mode);
endinterface : mode_bus_if

// ===== core/mode_select.sv
`timescale 1ns/1ps
module mode_select
   import fault_diag_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Mode words
   mode_bus_if.sel mb
);
   logic [1:0] valid_mode_reg;

   // Both bits set is not a mode: hold the last valid one
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         valid_mode_reg <= MODE_RESET;
      end else if (mb.raw_mode != MODE_BOTH) begin
         valid_mode_reg <= mb.raw_mode;
      end
   end

   always_comb begin
      if (mb.raw_mode == MODE_BOTH) begin
         mb.eff_mode = valid_mode_reg;
      end else begin
         mb.eff_mode = mb.raw_mode;
      end
   end
endmodule : mode_select

// ===== core/led_driver_fault_diagnostics.sv
`timescale 1ns/1ps
// Functional notes
// - Open-load check needs enable sense and mode
// - Auto-shutdown: any fault turns all channels off
// - Fault pulls shared line low, else released
// - Auto-shutdown: external low turns channels off
// - Channels recover automatically once faults clear
// - Detect-only: report fault, regulation unchanged
// - Detect-only: external low keeps channels on
// - Diagnostic modes set readable open-load flag
// - No mode bits: no open-load detection
// - Both bits set: keep previous mode
// - Enable sense low: suspend open-load detection
// - External low sets flag, clears others
// - Current-set short: all off, line, flag
// - Mode from nonvolatile or register copies
// - Nonvolatile access only in programming window
// - Serial flag set switches to register mode
module led_driver_fault_diagnostics
   import fault_diag_pkg::*;
#(
   parameter int CHANNELS = NUM_CHANNELS
)
(
   // Clock and reset
   input wire logic CLK,
   input wire logic RST_B,
   // Detector inputs
   input wire logic [CHANNELS-1:0] OPEN_LOAD_DET,
   input wire logic CURRENT_SET_SHORT,
   input wire logic DIAG_ENABLE_SENSE,
   input wire logic CURRENT_SET_PIN_IN_PROG_WINDOW,
   // Mode sources
   input wire logic SERIAL_MODE_FLAG,
   input wire logic AUTO_SHUTDOWN_ON_FAULT,
   input wire logic DETECT_WITHOUT_ACTION,
   input wire logic REG_AUTO_SHUTDOWN_ON_FAULT,
   input wire logic REG_DETECT_WITHOUT_ACTION,
   // Shared open-drain fault line
   input wire logic FAULT_LINE_IN,
   output logic FAULT_LINE_OUT,
   output logic FAULT_LINE_OE_B,
   // Channel control and status
   output logic [CHANNELS-1:0] CHANNEL_ON,
   output logic OPEN_LOAD_FLAG,
   output logic CURRENT_SET_SHORT_FLAG,
   output logic EXTERNAL_FAULT_FLAG,
   output logic [CHANNELS-1:0] OPEN_LOAD_STATUS,
   output logic NV_ACCESS_ENABLE
);
   // Elaboration-time refusal of a channel count the logic cannot serve
   if (CHANNELS < 1) begin : g_bad_channels
      $error("CHANNELS must be at least 1");
   end

   mode_bus_if mb ();

   logic auto_sd;
   logic det_only;
   logic ol_active;
   logic ol_any;
   logic ext_low;
   logic drive_low;
   logic all_off;

   // Standalone uses nonvolatile bits; serial flag swaps in register copies
   always_comb begin
      if (SERIAL_MODE_FLAG) begin
         mb.raw_mode = {REG_DETECT_WITHOUT_ACTION,
                        REG_AUTO_SHUTDOWN_ON_FAULT};
      end else begin
         mb.raw_mode = {DETECT_WITHOUT_ACTION,
                        AUTO_SHUTDOWN_ON_FAULT};
      end
   end

   mode_select u_mode_select (
      .clk(CLK),
      .rst_b(RST_B),
      .mb(mb)
   );

   assign auto_sd = mb.eff_mode[MODE_AUTO_BIT];
   assign det_only = mb.eff_mode[MODE_DETECT_BIT];

   // Either single-bit mode plus enable sense arms the open-load check
   assign ol_active = DIAG_ENABLE_SENSE && (auto_sd || det_only);
   assign ol_any = ol_active && (|OPEN_LOAD_DET);

   // Own drive is registered, so our low level is known from the flop
   assign ext_low = !FAULT_LINE_IN && FAULT_LINE_OE_B;

   assign drive_low = ol_any || CURRENT_SET_SHORT;

   // Short always shuts off; others only under auto-shutdown
   assign all_off = CURRENT_SET_SHORT
                    || (auto_sd && (ol_any || ext_low));

   // Fault line: enable active low while pulling
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         FAULT_LINE_OUT <= 1'b0;
         FAULT_LINE_OE_B <= 1'b1;
      end else begin
         FAULT_LINE_OUT <= 1'b0;
         FAULT_LINE_OE_B <= !drive_low;
      end
   end

   // Channels follow fault state every cycle, so recovery needs no software
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         CHANNEL_ON <= '0;
      end else begin
         CHANNEL_ON <= all_off ? '0 : '1;
      end
   end

   // Status flags; external fault masks open-load and short flags
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         OPEN_LOAD_FLAG <= 1'b0;
         CURRENT_SET_SHORT_FLAG <= 1'b0;
         EXTERNAL_FAULT_FLAG <= 1'b0;
         OPEN_LOAD_STATUS <= '0;
      end else begin
         EXTERNAL_FAULT_FLAG <= ext_low;
         OPEN_LOAD_FLAG <= ol_any && !ext_low;
         CURRENT_SET_SHORT_FLAG <= CURRENT_SET_SHORT && !ext_low;
         OPEN_LOAD_STATUS <= (ol_active && !ext_low) ?
                             OPEN_LOAD_DET : '0;
      end
   end

   // Nonvolatile access gate
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         NV_ACCESS_ENABLE <= 1'b0;
      end else begin
         NV_ACCESS_ENABLE <= CURRENT_SET_PIN_IN_PROG_WINDOW;
      end
   end
endmodule : led_driver_fault_diagnostics

// ===== verif/fault_line_partner.sv
`timescale 1ns/1ps
module fault_line_partner (
   // Other drivers and host
   input wire logic pull_low,
   // Device side
   input wire logic line_out,
   input wire logic line_oe_b,
   output logic line_in
);
   // Pull-up: resolved at once, so our own release never reads as external
   assign line_in = !pull_low && (line_oe_b || line_out);
endmodule : fault_line_partner

// ===== verif/fault_diag_properties.sv
`timescale 1ns/1ps
module fault_diag_chk
   import fault_diag_pkg::*;
#(parameter int CHANNELS = NUM_CHANNELS)
(
   // Clock, reset and watched pins
   input wire logic CLK, RST_B, CURRENT_SET_SHORT, DIAG_ENABLE_SENSE,
   input wire logic SERIAL_MODE_FLAG, AUTO_SHUTDOWN_ON_FAULT,
   input wire logic DETECT_WITHOUT_ACTION, REG_AUTO_SHUTDOWN_ON_FAULT,
   input wire logic REG_DETECT_WITHOUT_ACTION, FAULT_LINE_IN,
   input wire logic FAULT_LINE_OUT, FAULT_LINE_OE_B, OPEN_LOAD_FLAG,
   input wire logic EXTERNAL_FAULT_FLAG,
   input wire logic [CHANNELS-1:0] OPEN_LOAD_DET, CHANNEL_ON
);
   logic au, de, ext, ok, ol;
   assign au = SERIAL_MODE_FLAG ? REG_AUTO_SHUTDOWN_ON_FAULT
      : AUTO_SHUTDOWN_ON_FAULT;
   assign de = SERIAL_MODE_FLAG ? REG_DETECT_WITHOUT_ACTION
      : DETECT_WITHOUT_ACTION;
   // Low line while we are released is another party's fault
   assign ext = !FAULT_LINE_IN && FAULT_LINE_OE_B;
   assign ok = !CURRENT_SET_SHORT && FAULT_LINE_IN;
   assign ol = DIAG_ENABLE_SENSE && |OPEN_LOAD_DET;
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   a_short_all_off: assert property (
      CURRENT_SET_SHORT |=> !CHANNEL_ON && !FAULT_LINE_OE_B) else $error("short");
   a_ext_flag_only: assert property (
      ext |=> EXTERNAL_FAULT_FLAG && !OPEN_LOAD_FLAG) else $error("ext flag");
   a_no_false_ext: assert property (
      FAULT_LINE_IN |=> !EXTERNAL_FAULT_FLAG) else $error("false ext");
   a_line_out_low: assert property (
      !FAULT_LINE_OUT) else $error("line out");
   a_auto_ol_off: assert property (
      au && !de && ol && !ext && !CURRENT_SET_SHORT |=>
      !CHANNEL_ON && !FAULT_LINE_OE_B && OPEN_LOAD_FLAG) else $error("auto");
   a_auto_ext_off: assert property (
      au && !de && ext |=> !CHANNEL_ON) else $error("auto ext");
   a_detect_keeps_on: assert property (
      !au && de && !CURRENT_SET_SHORT |=> &CHANNEL_ON) else $error("detect");
   a_none_quiet: assert property (
      !au && !de && ok |=> FAULT_LINE_OE_B && !OPEN_LOAD_FLAG) else $error("none");
   a_recover_on: assert property (
      !ol && ok |=> &CHANNEL_ON && FAULT_LINE_OE_B) else $error("recover");
endmodule : fault_diag_chk
bind led_driver_fault_diagnostics fault_diag_chk #(.CHANNELS(CHANNELS))
   chk_u (.*);

// ===== verif/led_driver_fault_diagnostics_tb_top.sv
`timescale 1ns/1ps
module led_driver_fault_diagnostics_tb_top;
   import fault_diag_pkg::*;
   logic clk = 1'h0, rst_b = 1'h0, win = 1'h0, ser = 1'h0, au = 1'h0;
   logic de = 1'h0, rau = 1'h0, rde = 1'h0, sh = 1'h0, se = 1'h0, pl = 1'h0;
   logic [11:0] det = 12'h000;
   logic line, out, oe_b, olf, scf, exf, nv;
   logic [11:0] ch, ols;
   int n_errors = 0;
   int checks = 0;
   initial begin
      forever #50 clk = ~clk;
   end
   led_driver_fault_diagnostics dut_u (.CLK(clk), .RST_B(rst_b),
      .OPEN_LOAD_DET(det), .CURRENT_SET_SHORT(sh), .DIAG_ENABLE_SENSE(se),
      .CURRENT_SET_PIN_IN_PROG_WINDOW(win), .SERIAL_MODE_FLAG(ser),
      .AUTO_SHUTDOWN_ON_FAULT(au), .DETECT_WITHOUT_ACTION(de),
      .REG_AUTO_SHUTDOWN_ON_FAULT(rau), .REG_DETECT_WITHOUT_ACTION(rde),
      .FAULT_LINE_IN(line), .FAULT_LINE_OUT(out), .FAULT_LINE_OE_B(oe_b),
      .CHANNEL_ON(ch), .OPEN_LOAD_FLAG(olf), .CURRENT_SET_SHORT_FLAG(scf),
      .EXTERNAL_FAULT_FLAG(exf), .OPEN_LOAD_STATUS(ols),
      .NV_ACCESS_ENABLE(nv));
   fault_line_partner line_u (.pull_low(pl), .line_out(out),
      .line_oe_b(oe_b), .line_in(line));
   task cmp(input logic [11:0] e_ch, input logic [4:0] e_f);
      checks++;
      if ({ch, nv, oe_b, scf, olf, exf} !== {e_ch, e_f}) begin
         n_errors++;
         $display("Error %0t outputs %h %b", $time, ch,
            {nv, oe_b, scf, olf, exf});
      end
   endtask : cmp
   // Per-channel open-load status, still standing right after t returns
   task cmp_ols(input logic [11:0] e_ols);
      checks++;
      if (ols !== e_ols) begin
         n_errors++;
         $display("Error %0t open-load status %h", $time, ols);
      end
   endtask : cmp_ols
   // Control word: window, serial, nv auto/detect, reg auto/detect,
   // short, sense, external pull
   task t(input logic [8:0] c, input logic [11:0] d, input logic [11:0] e_ch,
      input logic [4:0] e_f);
      @(posedge clk);
      {win, ser, au, de, rau, rde, sh, se, pl} <= c;
      det <= d;
      @(posedge clk);
      #1 cmp(e_ch, e_f);
      $display("test done %0t", $time);
   endtask : t
   task complete_run;
      $display("checks %0d errors %0d", checks, n_errors);
      if (n_errors == 0 && checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask : complete_run
   initial begin
      repeat (6) @(posedge clk);
      cmp(12'h000, 5'h08);
      rst_b <= 1'h1;
      t(9'h042, 12'h008, 12'h000, 5'h02);
      cmp_ols(12'h008);
      t(9'h042, 12'h000, 12'hFFF, 5'h08);
      t(9'h062, 12'h008, 12'h000, 5'h02);
      t(9'h040, 12'h008, 12'hFFF, 5'h08);
      t(9'h022, 12'h800, 12'hFFF, 5'h02);
      cmp_ols(12'h800);
      t(9'h002, 12'hFFF, 12'hFFF, 5'h08);
      cmp_ols(12'h000);
      t(9'h023, 12'h000, 12'hFFF, 5'h09);
      t(9'h043, 12'h000, 12'h000, 5'h09);
      t(9'h004, 12'h000, 12'h000, 5'h04);
      t(9'h092, 12'h001, 12'h000, 5'h02);
      cmp_ols(12'h001);
      t(9'h0C2, 12'h001, 12'hFFF, 5'h08);
      t(9'h102, 12'h000, 12'hFFF, 5'h18);
      complete_run();
   end
endmodule : led_driver_fault_diagnostics_tb_top
